// File: common/wdt_pkg.sv
// Purpose: shared constants and types for the keyed watchdog timer
// Assumes: 32-bit APB register bus, 50 MHz system clock
// Notes: register offsets are byte addresses, one aligned word each
package wdt_pkg;

	// ***************************************
	// register map
	// ***************************************
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] cause_off = 8'h04;
	localparam logic [7:0] status_off = 8'h08;
	localparam logic [7:0] irq_clr_off = 8'h0c;
	localparam logic [7:0] irq_en_off = 8'h10;
	localparam logic [7:0] count_off = 8'h14;
	localparam logic [7:0] irq_stat_off = 8'h18;

	// ***************************************
	// fields and reset values
	// ***************************************
	localparam int key_lsb = 3;
	localparam int sel_lsb = 0;
	localparam logic [7:0] ctrl_reset = 8'h53;
	localparam logic [4:0] key_a = 5'h15;
	localparam logic [4:0] key_b = 5'h0a;
	localparam int key_fault_bit = 0;
	localparam int timeout_bit = 0;
	localparam int power_down_bit = 1;
	localparam int irq_ovf_bit = 0;
	localparam int irq_key_bit = 1;
	localparam int cnt_w = 18;

	// ***************************************
	// timing
	// ***************************************
	localparam int clk_hz = 50000000;
	localparam int key_fault_delay_us = 64;
	localparam int key_fault_delay_cyc = (key_fault_delay_us * (clk_hz / 1000000) > 0) ?
		key_fault_delay_us * (clk_hz / 1000000) : 1;

	// ***************************************
	// types
	// ***************************************
	typedef struct packed {
		logic [4:0] key;
		logic [2:0] sel;
	} ctrl_t;

	typedef struct packed {
		logic full_reset;
		logic core_reset;
	} reset_req_t;

	typedef enum logic [1:0] {
		key_ok,
		key_wait,
		key_trip
	} key_state_t;

endpackage : wdt_pkg

// File: design/keyed_watchdog_timer.sv
// Purpose: keyed watchdog timer with APB register access
// Assumes: slow oscillator tick arrives as an asynchronous level, synchronised here
// Notes: reset requests are one-cycle pulses to the system reset controller
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns

// Functional notes
// - counter advances only on slow oscillator edges, not the system clock
// - period codes 0..6 pick 2^8,10,12,14,15,16,17 slow cycles
// - counting while key equals 10101 or 01010
// - any other key value gives full reset after a fixed delay
// - key fault reset sets key fault flag; only rst_in or a software zero clears it
// - control register resets to 0x53, watchdog running
// - overflow when awake gives full reset and sets timeout flag
// - overflow asleep sets timeout flag, resets only program counter and stack
// - counter cleared by key fault reset, clear instruction, or halt
// - no register write clears the counter
// - reset cause bits seven to three read zero
// - halt sets power down flag, clears timeout flag and counter
// - clear instruction also clears power down flag
// - overflow while asleep wakes the device
module keyed_watchdog_timer
	import wdt_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// slow oscillator and core events
	input wire logic slow_osc_in,
	input wire logic asleep_in,
	input wire logic clear_instr_in,
	input wire logic halt_instr_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// resets and interrupt
	output reset_req_t reset_req_out,
	output logic wake_out,
	output logic irq_out
);

	// ***************************************
	// declarations
	// ***************************************
	ctrl_t ctrl_q;
	logic key_fault_flag_q;
	logic timeout_status_flag_q;
	logic power_down_flag_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_en_q;
	logic [cnt_w-1:0] count_q;
	logic [2:0] osc_sync_q;
	logic osc_level_q;
	logic tick;
	logic overflow;
	logic key_valid;
	key_state_t key_state_q;
	logic [31:0] delay_q;
	logic key_fire;
	logic wr;
	logic mapped;

	// true when the key field holds a valid pattern
	function automatic logic key_is_valid(input logic [4:0] k);
		key_is_valid = (k == key_a) || (k == key_b);
	endfunction : key_is_valid

	// top counter bit that marks overflow for a period code
	function automatic int unsigned period_bit(input logic [2:0] s);
		case (s)
			3'h0: period_bit = 8;
			3'h1: period_bit = 10;
			3'h2: period_bit = 12;
			3'h3: period_bit = 14;
			3'h4: period_bit = 15;
			3'h5: period_bit = 16;
			3'h6: period_bit = 17;
			default: period_bit = 18;
		endcase
	endfunction : period_bit

	// ***************************************
	// apb decode
	// ***************************************
	assign wr = psel_in && penable_in && pwrite_in;
	assign pready_out = 1'b1;
	// irq status is readable so software can tell which event raised the line
	assign mapped = (paddr_in == ctrl_off) || (paddr_in == cause_off) || (paddr_in == status_off)
		|| (paddr_in == irq_clr_off) || (paddr_in == irq_en_off) || (paddr_in == count_off)
		|| (paddr_in == irq_stat_off);
	assign pslverr_out = psel_in && penable_in && !mapped;

	// read data registered on the setup edge; visible during the access phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0;
		end else if (ce_in && psel_in && !penable_in && !pwrite_in) begin
			case (paddr_in)
				ctrl_off: prdata_out <= {24'h0, ctrl_q};
				cause_off: prdata_out <= {29'h0, 2'h0, key_fault_flag_q};
				status_off: prdata_out <= {30'h0, power_down_flag_q, timeout_status_flag_q};
				irq_en_off: prdata_out <= {30'h0, irq_en_q};
				count_off: prdata_out <= {14'h0, count_q};
				irq_stat_off: prdata_out <= {30'h0, irq_stat_q};
				default: prdata_out <= 32'h0;
			endcase
		end
	end

	// ***************************************
	// slow oscillator synchroniser
	// ***************************************
	// three stages; a new level counts once stages two and three agree
	// a single-stage glitch on the slow pin therefore never reaches the counter
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			osc_sync_q <= 3'h0;
			osc_level_q <= 1'b0;
		end else if (ce_in) begin
			osc_sync_q <= {osc_sync_q[1:0], slow_osc_in};
			if (osc_sync_q[1] == osc_sync_q[2]) begin
				osc_level_q <= osc_sync_q[2];
			end
		end
	end
	assign tick = (osc_sync_q[1] == osc_sync_q[2]) && osc_sync_q[2] && !osc_level_q;

	// ***************************************
	// control register
	// ***************************************
	// a bad key stays visible until the fault reset reloads defaults
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_q <= ctrl_reset;
		end else if (ce_in) begin
			if (key_fire) begin
				ctrl_q <= ctrl_reset;
			end else if (wr && paddr_in == ctrl_off) begin
				ctrl_q <= pwdata_in[7:0];
			end
		end
	end
	assign key_valid = key_is_valid(ctrl_q.key);

	// ***************************************
	// key fault delay
	// ***************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			key_state_q <= key_ok;
			delay_q <= 32'h0;
		end else if (ce_in) begin
			case (key_state_q)
				key_ok: begin
					delay_q <= 32'h0;
					if (!key_valid) begin
						key_state_q <= key_wait;
					end
				end
				key_wait: begin
					delay_q <= delay_q + 32'h1;
					if (delay_q == 32'(key_fault_delay_cyc - 1)) begin
						key_state_q <= key_trip;
					end
				end
				key_trip: key_state_q <= key_ok;
				default: key_state_q <= key_ok;
			endcase
		end
	end
	assign key_fire = ce_in && (key_state_q == key_trip);

	// ***************************************
	// watchdog counter
	// ***************************************
	assign overflow = ce_in && key_valid && tick && (count_q == cnt_w'((1 << period_bit(ctrl_q.sel)) - 1));
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count_q <= '0;
		end else if (ce_in) begin
			if (key_fire || clear_instr_in || halt_instr_in || overflow) begin
				count_q <= '0;
			end else if (key_valid && tick) begin
				count_q <= count_q + 1'b1;
			end
		end
	end

	// ***************************************
	// status flags
	// ***************************************
	// key fault flag: set wins over software clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			key_fault_flag_q <= 1'b0;
		end else if (ce_in) begin
			if (key_fire) begin
				key_fault_flag_q <= 1'b1;
			end else if (wr && paddr_in == cause_off && !pwdata_in[key_fault_bit]) begin
				key_fault_flag_q <= 1'b0;
			end
		end
	end

	// timeout and power down flags follow halt, clear and overflow
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			timeout_status_flag_q <= 1'b0;
			power_down_flag_q <= 1'b0;
		end else if (ce_in) begin
			if (overflow) begin
				timeout_status_flag_q <= 1'b1;
			end else if (halt_instr_in) begin
				timeout_status_flag_q <= 1'b0;
			end
			if (halt_instr_in) begin
				power_down_flag_q <= 1'b1;
			end else if (clear_instr_in) begin
				power_down_flag_q <= 1'b0;
			end
		end
	end

	// ***************************************
	// reset requests and wake
	// ***************************************
	assign reset_req_out.full_reset = key_fire || (overflow && !asleep_in);
	assign reset_req_out.core_reset = overflow && asleep_in;
	assign wake_out = overflow && asleep_in;

	// ***************************************
	// interrupts
	// ***************************************
	// sticky status; new events win over the clear register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_stat_q <= 2'h0;
			irq_en_q <= 2'h0;
		end else if (ce_in) begin
			irq_stat_q <= (irq_stat_q & ~((wr && paddr_in == irq_clr_off) ? pwdata_in[1:0] : 2'h0))
				| {key_fire, overflow};
			if (wr && paddr_in == irq_en_off) begin
				irq_en_q <= pwdata_in[1:0];
			end
		end
	end
	assign irq_out = |(irq_stat_q & irq_en_q);

	// ***************************************
	// assertions
	// ***************************************
	property p_fault_flag;
		@(posedge clk_in) disable iff (rst_in) key_fire |=> key_fault_flag_q;
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("key fault flag not set");

	property p_fault_delay;
		@(posedge clk_in) disable iff (rst_in) key_fire |-> (delay_q == 32'(key_fault_delay_cyc));
	endproperty
	a_fault_delay: assert property (p_fault_delay) else $error("key fault reset too early");

	property p_ovf_awake;
		@(posedge clk_in) disable iff (rst_in) (overflow && !asleep_in) |-> reset_req_out.full_reset
			##1 timeout_status_flag_q;
	endproperty
	a_ovf_awake: assert property (p_ovf_awake) else $error("overflow without full reset");

	property p_ovf_sleep;
		@(posedge clk_in) disable iff (rst_in) (overflow && asleep_in) |-> (reset_req_out.core_reset && wake_out
			&& !reset_req_out.full_reset);
	endproperty
	a_ovf_sleep: assert property (p_ovf_sleep) else $error("sleep overflow wrong reset");

	property p_clear;
		@(posedge clk_in) disable iff (rst_in) (ce_in && clear_instr_in) |=> (count_q == '0 && !power_down_flag_q);
	endproperty
	a_clear: assert property (p_clear) else $error("clear instruction ineffective");

	property p_halt;
		@(posedge clk_in) disable iff (rst_in) (ce_in && halt_instr_in && !overflow) |=>
			(power_down_flag_q && !timeout_status_flag_q);
	endproperty
	a_halt: assert property (p_halt) else $error("halt flags wrong");

	property p_no_count_bad_key;
		@(posedge clk_in) disable iff (rst_in) (ce_in && !key_valid && !clear_instr_in && !halt_instr_in
			&& !key_fire) |=> count_q == $past(count_q);
	endproperty
	a_no_count_bad_key: assert property (p_no_count_bad_key) else $error("counting with bad key");

	property p_write_no_clear;
		@(posedge clk_in) disable iff (rst_in) (ce_in && !tick && !clear_instr_in && !halt_instr_in && !key_fire
			&& count_q != '0) |=> count_q == $past(count_q);
	endproperty
	a_write_no_clear: assert property (p_write_no_clear) else $error("counter changed without cause");

endmodule : keyed_watchdog_timer

// File: verif/keyed_watchdog_timer_tb.sv
// Purpose: self-checking bench for the keyed watchdog timer
// Assumes: zero wait state apb slave, slow tick driven well below clock rate
// Notes: reads and reset pulses are noted in queues and compared by a monitor
`timescale 1ns/1ns
module keyed_watchdog_timer_tb import wdt_pkg::*;;
	// ***************************************
	// signals
	// ***************************************
	logic clk_in = 0, rst_in = 1, ce_in = 1, slow_osc_in = 0, asleep_in = 0;
	logic clear_instr_in = 0, halt_instr_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out;
	logic pready_out, pslverr_out, wake_out, irq_out;
	reset_req_t reset_req_out;
	int mismatches = 0, num_checks = 0, seed = 32'h97694c4a, k;
	logic [65:0] rd_q[$];
	logic [2:0] rst_q[$];
	logic [65:0] e;
	logic [2:0] e3;
	localparam logic [32:0] all = '1;

	always #10 clk_in = ~clk_in;

	keyed_watchdog_timer uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .slow_osc_in(slow_osc_in),
		.asleep_in(asleep_in), .clear_instr_in(clear_instr_in), .halt_instr_in(halt_instr_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.reset_req_out(reset_req_out), .wake_out(wake_out), .irq_out(irq_out));

	// ***************************************
	// tasks
	// ***************************************
	task check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude

	// one apb transfer; a read notes {mask, {pslverr, prdata}}
	task apb(input logic w, input logic [7:0] a, input logic [32:0] x, input logic [32:0] m);
		int n;
		@(posedge clk_in);
		if (!w) rd_q.push_back({m, x});
		psel_in <= 1;
		penable_in <= 0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= w ? x[31:0] : $random(seed);
		@(posedge clk_in) penable_in <= 1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			conclude();
		end
		psel_in <= 0;
		penable_in <= 0;
	endtask : apb

	// slow ticks far apart so the synchroniser sees every edge
	task tick(input int n);
		repeat (n) begin
			@(posedge clk_in) slow_osc_in <= 1;
			repeat (4) @(posedge clk_in);
			slow_osc_in <= 0;
			repeat (4) @(posedge clk_in);
		end
		repeat (6) @(posedge clk_in);
	endtask : tick

	task pulse(input int h);
		@(posedge clk_in);
		if (h) halt_instr_in <= 1;
		else clear_instr_in <= 1;
		@(posedge clk_in);
		halt_instr_in <= 0;
		clear_instr_in <= 0;
	endtask : pulse

	// ***************************************
	// monitor
	// ***************************************
	// falling edge: outputs settled, an unnoted reset pulse is a mismatch
	always @(negedge clk_in) begin
		if (psel_in && penable_in && !pwrite_in) begin
			e = rd_q.pop_front();
			check({pslverr_out, prdata_out} & e[65:33], e[32:0]);
		end
		if (reset_req_out !== 2'b00) begin
			e3 = rst_q.size() ? rst_q.pop_front() : 3'b000;
			check({30'h0, wake_out, reset_req_out}, {30'h0, e3});
		end
	end

	// ***************************************
	// main sequence
	// ***************************************
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 0;
		apb(0, ctrl_off, {25'h0, ctrl_reset}, all);
		apb(0, cause_off, 33'h0, all);
		apb(0, status_off, 33'h0, all);
		apb(0, count_off, 33'h0, all);
		apb(0, 8'h20, 33'h100000000, all);
		apb(1, irq_en_off, 33'h3, all);
		$display("test reset done");
		pulse(0);
		k = 1 + ($random(seed) & 15);
		tick(k);
		apb(0, count_off, 33'(k), all);
		// clock enable low: slow edges must be ignored and the count frozen
		@(posedge clk_in) ce_in <= 0;
		tick(3);
		@(posedge clk_in) ce_in <= 1;
		apb(0, count_off, 33'(k), all);
		apb(1, ctrl_off, {1'b0, 24'($random(seed)), key_a, 3'b000}, all);
		apb(0, count_off, 33'(k), all);
		apb(0, ctrl_off, {25'h0, key_a, 3'b000}, all);
		pulse(0);
		tick(254);
		rst_q.push_back(3'b010);
		tick(2);
		check(33'(rst_q.size()), 33'h0);
		check({32'h0, irq_out}, 33'h1);
		apb(0, status_off, 33'h1, all);
		apb(0, irq_stat_off, 33'h1, all);
		apb(1, irq_clr_off, 33'h1, all);
		@(negedge clk_in) check({32'h0, irq_out}, 33'h0);
		$display("test awake overflow done");
		@(posedge clk_in) asleep_in <= 1;
		pulse(1);
		apb(0, status_off, 33'h2, all);
		apb(1, ctrl_off, {25'h0, key_b, 3'b001}, all);
		tick(1022);
		rst_q.push_back(3'b101);
		tick(2);
		check(33'(rst_q.size()), 33'h0);
		apb(0, status_off, 33'h3, all);
		@(posedge clk_in) asleep_in <= 0;
		pulse(0);
		apb(0, status_off, 33'h0, 33'h2);
		apb(1, irq_clr_off, 33'h3, all);
		@(negedge clk_in) check({32'h0, irq_out}, 33'h0);
		$display("test sleep overflow done");
		// bad key: one full reset after the fixed delay
		tick(3);
		apb(1, ctrl_off, {25'h0, 5'h1f, 3'b000}, all);
		rst_q.push_back(3'b010);
		tick(3);
		repeat (key_fault_delay_cyc) @(posedge clk_in);
		check(33'(rst_q.size()), 33'h0);
		check({32'h0, irq_out}, 33'h1);
		apb(0, irq_stat_off, 33'h2, all);
		apb(0, cause_off, 33'h1, all);
		apb(0, ctrl_off, {25'h0, ctrl_reset}, all);
		apb(0, count_off, 33'h0, all);
		apb(1, cause_off, 33'h0, all);
		apb(0, cause_off, 33'h0, all);
		apb(1, irq_clr_off, 33'h2, all);
		@(negedge clk_in) check({32'h0, irq_out}, 33'h0);
		$display("test key fault done");
		conclude();
	end
endmodule : keyed_watchdog_timer_tb
